// ==== pkg/upd_ctrl_pkg.sv ====
// constants and types shared by the parameter commit controller
package upd_ctrl_pkg;

  // **********************************************************
  // register map, byte offsets on the bus
  // **********************************************************
  localparam int          ADDR_W   = 8;
  localparam logic [7:0]  CTRL_OFF = 8'h00;
  localparam logic [7:0]  RATE_OFF = 8'h04;
  localparam logic [7:0]  AMP_OFF  = 8'h08;
  localparam logic [7:0]  ACT_OFF  = 8'h0C;
  localparam logic [7:0]  STAT_OFF = 8'h10;

  // **********************************************************
  // bus encodings
  // **********************************************************
  localparam logic [2:0]  SIZE_WORD = 3'h2;
  localparam logic        RESP_OKAY = 1'b0;

  // **********************************************************
  // timing and reset values
  // **********************************************************
  localparam int          QUARTER_DIV  = 4;
  localparam logic [1:0]  QUARTER_LAST = 2'(QUARTER_DIV - 1);
  localparam int          PULSE_CYC    = 12;
  localparam logic [3:0]  PULSE_LOAD   = 4'(PULSE_CYC);
  localparam logic [31:0] RATE_MIN     = 32'h0000_0003;
  localparam logic [31:0] RATE_RESET   = 32'h0000_0000;
  localparam logic [15:0] TIMER_ONE    = 16'h0001;
  localparam logic [3:0]  STEP_UNIT    = 4'h1;

  // **********************************************************
  // register layouts
  // **********************************************************
  typedef struct packed {
    logic [26:0] rsvd;
    logic        rampTimerReloadOnCommit;
    logic        autoRampSelect;
    logic [1:0]  rateCtl;
    logic        intCommitEn;
  } ctrl_t;

  typedef struct packed {
    logic [15:0] interval;
    logic [13:0] maxAmp;
    logic [1:0]  step;
  } amp_word_t;

  typedef struct packed {
    logic [15:0] timerCount;
    logic [9:0]  rsvd;
    logic        autoActive;
    logic        rampUp;
    logic        strobeLevel;
    logic [2:0]  profile;
  } status_t;

endpackage

// ==== hdl/pin_sync.sv ====
// three-flop synchroniser with agreement filter and change pulse
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rstN,
  // pin side
  input  wire logic [W-1:0] pinIn,
  // synchronised side
  output logic      [W-1:0] level,
  output logic              changed
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;
  logic [W-1:0] stage3_reg;
  logic [W-1:0] level_reg;
  wire          agree = (stage2_reg == stage3_reg);

  // stage1 only feeds stage2; filtering starts at stage2/3
  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      level_reg  <= '0;
    end
    else
    begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      if (agree)
        level_reg <= stage3_reg;
    end
  end

  assign level   = level_reg;
  assign changed = agree && (stage3_reg != level_reg);

endmodule

// ==== hdl/ramp_timer.sv ====
// 16-bit ramp interval timer with self reload and forced reload
module ramp_timer (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstN,
  // control
  input  wire logic        tickEn,
  input  wire logic        run,
  input  wire logic        reload,
  input  wire logic [15:0] interval,
  // state
  output logic             expire,
  output logic      [15:0] count
);

  logic [15:0] count_reg;
  wire         atEnd = (count_reg <= upd_ctrl_pkg::TIMER_ONE);

  assign expire = run && tickEn && atEnd && !reload;
  assign count  = count_reg;

  // a zero interval expires on every tick rather than wrapping
  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
      count_reg <= '0;
    else if (reload || !run)
      count_reg <= interval;
    else if (tickEn)
      count_reg <= atEnd ? interval : count_reg - upd_ctrl_pkg::TIMER_ONE;
  end

  self_reload_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    expire |=> count_reg == $past(interval))
    else $error("timer did not reload on expiry");

  forced_reload_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    reload |-> !expire ##1 count_reg == $past(interval))
    else $error("forced reload not taken");

endmodule

// ==== hdl/param_update_profile_ctrl.sv ====
// parameter commit, profile select and ramp timer control with an AHB-Lite slave
module param_update_profile_ctrl (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  // AHB-Lite slave
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic      [31:0]              hrdata,
  // commit strobe pin, two-way
  input  wire logic                     strobeIn,
  output logic                          strobeOut,
  output logic                          strobeOe,
  // profile and ramp direction pins
  input  wire logic [2:0]               profileSel,
  input  wire logic                     outputKeying,
  // working hardware side
  output upd_ctrl_pkg::amp_word_t       activeAmp,
  output logic      [3:0]               stepSize,
  output logic      [2:0]               activeProfile,
  output logic                          rampUp,
  output logic                          rampTick,
  output logic                          commitPulse
);

  // **********************************************************
  // reset release
  // **********************************************************
  logic [1:0] rstPipe_reg;
  wire        rstN = rstPipe_reg[1];

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rstPipe_reg <= '0;
    else
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
  end

  // **********************************************************
  // pin synchronisers
  // **********************************************************
  logic       strobeLvl;
  logic       strobeChg;
  logic [2:0] profLvl;
  logic       profChg;
  logic       dirLvl;
  logic       dirChg;

  pin_sync #(.W(1)) strobeSync (
    .clk_sys (clk_sys),
    .rstN    (rstN),
    .pinIn   (strobeIn),
    .level   (strobeLvl),
    .changed (strobeChg)
  );

  pin_sync #(.W(3)) profileSync (
    .clk_sys (clk_sys),
    .rstN    (rstN),
    .pinIn   (profileSel),
    .level   (profLvl),
    .changed (profChg)
  );

  pin_sync #(.W(1)) dirSync (
    .clk_sys (clk_sys),
    .rstN    (rstN),
    .pinIn   (outputKeying),
    .level   (dirLvl),
    .changed (dirChg)
  );

  // **********************************************************
  // registers
  // **********************************************************
  upd_ctrl_pkg::ctrl_t     ctrl_reg;
  upd_ctrl_pkg::ctrl_t     ctrlIn;
  upd_ctrl_pkg::amp_word_t ampProg_reg;
  upd_ctrl_pkg::amp_word_t ampAct_reg;
  upd_ctrl_pkg::status_t   status;
  logic [31:0]             rate_reg;
  logic                    autoAct_reg;
  logic [3:0]              stepSize_reg;
  logic [15:0]             timerCount;

  // **********************************************************
  // bus slave: zero wait states, always OKAY
  // **********************************************************
  logic                    wrPend_reg;
  logic [7:0]              wrAddr_reg;
  logic [31:0]             rdData_reg;
  wire                     addrValid = hsel && hready && htrans[1];
  wire  [7:0]              aAddr     = haddr[upd_ctrl_pkg::ADDR_W-1:0];
  wire                     wordSize  = (hsize == upd_ctrl_pkg::SIZE_WORD);
  wire                     wrCtrl    = wrPend_reg && (wrAddr_reg == upd_ctrl_pkg::CTRL_OFF);
  wire                     wrRate    = wrPend_reg && (wrAddr_reg == upd_ctrl_pkg::RATE_OFF);
  wire                     wrAmp     = wrPend_reg && (wrAddr_reg == upd_ctrl_pkg::AMP_OFF);
  wire  [31:0]             rdMux;

  always_comb
  begin
    ctrlIn      = upd_ctrl_pkg::ctrl_t'(hwdata);
    ctrlIn.rsvd = '0;
  end

  assign rdMux =
    (aAddr == upd_ctrl_pkg::CTRL_OFF) ? 32'(ctrl_reg)    :
    (aAddr == upd_ctrl_pkg::RATE_OFF) ? rate_reg         :
    (aAddr == upd_ctrl_pkg::AMP_OFF)  ? 32'(ampProg_reg) :
    (aAddr == upd_ctrl_pkg::ACT_OFF)  ? 32'(ampAct_reg)  :
    (aAddr == upd_ctrl_pkg::STAT_OFF) ? 32'(status)      :
                                        32'h0000_0000;

  // read data is captured in the address phase, so a read right
  // behind a write to the same word still returns the old value
  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= '0;
      rdData_reg <= '0;
    end
    else
    begin
      wrPend_reg <= addrValid && hwrite && wordSize;
      if (addrValid)
        wrAddr_reg <= aAddr;
      if (addrValid && !hwrite)
        rdData_reg <= rdMux;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = upd_ctrl_pkg::RESP_OKAY;
  assign hrdata    = rdData_reg;

  // programming registers; the amplitude word stays here until a commit
  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      ctrl_reg    <= '0;
      rate_reg    <= upd_ctrl_pkg::RATE_RESET;
      ampProg_reg <= '0;
    end
    else
    begin
      if (wrCtrl)
        ctrl_reg <= ctrlIn;
      if (wrRate)
        rate_reg <= hwdata;
      if (wrAmp)
        ampProg_reg <= upd_ctrl_pkg::amp_word_t'(hwdata);
    end
  end

  // **********************************************************
  // quarter-rate and rate dividers
  // **********************************************************
  logic [1:0]  quarter_reg;
  logic [2:0]  rateDiv_reg;
  logic [31:0] rateCnt_reg;
  wire         quarterEn = (quarter_reg == upd_ctrl_pkg::QUARTER_LAST);
  wire  [2:0]  rateMask  = 3'((4'h1 << ctrl_reg.rateCtl) - 4'h1);
  wire         rateEn    = quarterEn && ((rateDiv_reg & rateMask) == rateMask);
  wire         rateLow   = (rate_reg <= upd_ctrl_pkg::RATE_MIN);
  wire         intMode   = ctrl_reg.intCommitEn;
  wire         rateHit   = (rateCnt_reg >= rate_reg - 32'h0000_0001);
  wire         intCommit = intMode && !rateLow && rateEn && rateHit;

  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      quarter_reg <= '0;
      rateDiv_reg <= '0;
      rateCnt_reg <= '0;
    end
    else
    begin
      quarter_reg <= quarter_reg + 2'h1;
      if (quarterEn)
        rateDiv_reg <= rateDiv_reg + 3'h1;
      if (!intMode || rateLow)
        rateCnt_reg <= '0;
      else if (rateEn)
        rateCnt_reg <= rateHit ? '0 : rateCnt_reg + 32'h0000_0001;
    end
  end

  // **********************************************************
  // commit sources
  // **********************************************************
  // own strobe drive is echoed back through the pin, so ignore it
  wire extRise = !intMode && strobeChg && !strobeLvl;
  wire commit  = extRise || profChg || intCommit;
  wire autoRise = commit && ctrl_reg.autoRampSelect && !autoAct_reg;

  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      ampAct_reg   <= '0;
      autoAct_reg  <= 1'b0;
      stepSize_reg <= upd_ctrl_pkg::STEP_UNIT;
    end
    else if (commit)
    begin
      ampAct_reg   <= ampProg_reg;
      autoAct_reg  <= ctrl_reg.autoRampSelect;
      stepSize_reg <= upd_ctrl_pkg::STEP_UNIT << ampProg_reg.step;
    end
  end

  // **********************************************************
  // strobe output drive
  // **********************************************************
  logic [3:0] pulseCnt_reg;
  logic       strobeOut_reg;
  logic [3:0] pulseNext;

  always_comb
  begin
    pulseNext = '0;
    if (intCommit)
      pulseNext = upd_ctrl_pkg::PULSE_LOAD;
    else if (pulseCnt_reg != '0)
      pulseNext = pulseCnt_reg - 4'h1;
  end

  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      pulseCnt_reg  <= '0;
      strobeOut_reg <= 1'b0;
    end
    else
    begin
      pulseCnt_reg  <= pulseNext;
      strobeOut_reg <= intMode && (rateLow || pulseNext != '0);
    end
  end

  assign strobeOut = strobeOut_reg;
  assign strobeOe  = intMode;

  // **********************************************************
  // ramp interval timer
  // **********************************************************
  wire        reloadCommit = commit && ctrl_reg.rampTimerReloadOnCommit;
  wire        timerReload  = autoRise || dirChg || reloadCommit;
  // a commit that reloads must load the interval it is committing
  wire [15:0] timerIval    = commit ? ampProg_reg.interval : ampAct_reg.interval;
  logic       timerExpire;
  logic       rampTick_reg;
  logic       commitPulse_reg;

  ramp_timer intervalTimer (
    .clk_sys  (clk_sys),
    .rstN     (rstN),
    .tickEn   (quarterEn),
    .run      (autoAct_reg),
    .reload   (timerReload),
    .interval (timerIval),
    .expire   (timerExpire),
    .count    (timerCount)
  );

  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      rampTick_reg    <= 1'b0;
      commitPulse_reg <= 1'b0;
    end
    else
    begin
      rampTick_reg    <= timerExpire;
      commitPulse_reg <= commit;
    end
  end

  // **********************************************************
  // outputs and status
  // **********************************************************
  always_comb
  begin
    status             = '0;
    status.timerCount  = timerCount;
    status.autoActive  = autoAct_reg;
    status.rampUp      = dirLvl;
    status.strobeLevel = strobeLvl;
    status.profile     = profLvl;
  end

  assign activeAmp     = ampAct_reg;
  assign stepSize      = stepSize_reg;
  assign activeProfile = profLvl;
  assign rampUp        = dirLvl;
  assign rampTick      = rampTick_reg;
  assign commitPulse   = commitPulse_reg;

  // **********************************************************
  // checks
  // **********************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstN);

  sequence pulseHigh8;
    strobeOut_reg [*8];
  endsequence

  sequence pulseTail;
    strobeOut_reg [*4] ##1 !strobeOut_reg;
  endsequence

  step_decode_a: assert property (
    commit |=> stepSize == (upd_ctrl_pkg::STEP_UNIT << $past(ampProg_reg.step)))
    else $error("step size does not match committed code");

  auto_reload_a: assert property (
    commit && ctrl_reg.autoRampSelect && !autoAct_reg |=> timerCount == $past(ampProg_reg.interval))
    else $error("auto ramp rise did not reload timer");

  dir_reload_a: assert property (
    dirChg |-> timerReload ##1 timerCount == $past(timerIval))
    else $error("direction change did not reload timer");

  commit_quiet_a: assert property (
    commit && !ctrl_reg.rampTimerReloadOnCommit && autoAct_reg && !dirChg && !quarterEn |=> $stable(timerCount))
    else $error("commit moved timer with reload bit clear");

  hold_params_a: assert property (
    !commit |=> $stable(ampAct_reg))
    else $error("working amplitude changed without commit");

  strobe_commit_a: assert property (
    extRise |=> commitPulse && ampAct_reg == $past(ampProg_reg))
    else $error("strobe edge did not commit");

  profile_commit_a: assert property (
    profChg |=> commitPulse ##0 activeProfile == $past(profileSync.stage3_reg))
    else $error("profile change did not commit");

  strobe_pulse_a: assert property (
    intCommit |=> pulseHigh8 ##1 pulseTail)
    else $error("internal strobe pulse not twelve cycles");

  rate_low_a: assert property (
    intMode && rateLow |=> strobeOut_reg)
    else $error("strobe not held high for small rate");

  quarter_tick_a: assert property (
    quarterEn |=> !quarterEn [*3] ##1 quarterEn)
    else $error("quarter rate enable spacing wrong");

endmodule

// ==== dv/strobe_host_model.sv ====
// external controller model driving the strobe, profile and direction pins
module strobe_host_model (
  // clock
  input  wire logic       clk_sys,
  // strobe pin, shared with the device
  input  wire logic       strobeOe,
  input  wire logic       strobeOut,
  output logic            strobePin,
  // profile and direction pins
  output logic      [2:0] profileSel,
  output logic            outputKeying
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drvOe;
  logic drvVal;
  initial
  begin
    drvOe = 1'b0;
    drvVal = 1'b0;
    profileSel = 3'h0;
    outputKeying = 1'b0;
  end
  // a pull-down holds the line low when nobody drives it
  assign strobePin = strobeOe ? strobeOut : (drvOe & drvVal);
  // raised after the writes, held long enough for the input filter
  task automatic commit_pulse();
    @(posedge clk_sys);
    drvOe <= 1'b1;
    drvVal <= 1'b1;
    repeat (3) @(posedge clk_sys);
    drvVal <= 1'b0;
    @(posedge clk_sys);
    drvOe <= 1'b0;
  endtask
  // index with bit 2 as msb
  task automatic set_profile(input logic [2:0] idx);
    @(posedge clk_sys);
    profileSel <= idx;
  endtask
  // flips the ramp direction
  task automatic set_direction();
    @(posedge clk_sys);
    outputKeying <= ~outputKeying;
  endtask
endmodule

// ==== dv/test_param_update_profile_ctrl.sv ====
// self-checking bench of the parameter commit controller
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("BAD %0t got %h expected %h", $time, got, exp); \
    end \
  end
module test_param_update_profile_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 10000;
  logic                    clk_sys = 1'b0;
  logic                    nrst = 1'b0;
  logic                    hsel = 1'b0;
  logic [31:0]             haddr = 32'h0;
  logic [1:0]              htrans = 2'h0;
  logic                    hwrite = 1'b0;
  logic [2:0]              hsize = 3'h0;
  logic [31:0]             hwdata = 32'h0;
  logic                    hreadyout;
  logic                    hresp;
  logic [31:0]             hrdata;
  logic                    strobePin;
  logic                    strobeOut;
  logic                    strobeOe;
  logic [2:0]              profileSel;
  logic                    outputKeying;
  upd_ctrl_pkg::amp_word_t activeAmp;
  logic [3:0]              stepSize;
  logic [2:0]              activeProfile;
  logic                    rampUp;
  logic                    rampTick;
  logic                    commitPulse;
  int                      miscompares = 0;
  int                      comparisons = 0;
  int                      cyc = 0;
  logic [31:0]             rng = 32'h2B06;
  logic [31:0]             readQ[$];
  logic [31:0]             ampQ[$];
  logic [31:0]             expRd;
  logic [31:0]             expAmp;
  logic [31:0]             holdAmp = 32'h0;
  logic                    autoMode = 1'b0;
  logic                    rdPhase = 1'b0;

  always #25 clk_sys = ~clk_sys;

  param_update_profile_ctrl param_update_profile_ctrl_inst (
    .clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .strobeIn(strobePin),
    .strobeOut(strobeOut), .strobeOe(strobeOe), .profileSel(profileSel),
    .outputKeying(outputKeying), .activeAmp(activeAmp), .stepSize(stepSize),
    .activeProfile(activeProfile), .rampUp(rampUp), .rampTick(rampTick),
    .commitPulse(commitPulse)
  );

  strobe_host_model strobe_host_model_inst (
    .clk_sys(clk_sys), .strobeOe(strobeOe), .strobeOut(strobeOut), .strobePin(strobePin),
    .profileSel(profileSel), .outputKeying(outputKeying)
  );

  // ********
  // closing, timeout and output watcher
  // ********
  task automatic complete_run();
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      miscompares++;
      complete_run();
    end
  end

  always @(posedge clk_sys)
  begin
    rdPhase <= hsel & htrans[1] & ~hwrite & hreadyout;
    if (rdPhase)
    begin
      expRd = readQ.pop_front();
      `CHK(hrdata, expRd);
      `CHK(hresp, upd_ctrl_pkg::RESP_OKAY);
    end
    if (commitPulse === 1'b1 && !autoMode && ampQ.size() == 0)
    begin
      miscompares++;
      $display("BAD %0t unexpected commit", $time);
    end
    else if (commitPulse === 1'b1)
    begin
      expAmp = autoMode ? holdAmp : ampQ.pop_front();
      `CHK(activeAmp, expAmp);
      `CHK(stepSize, 4'(upd_ctrl_pkg::STEP_UNIT << expAmp[1:0]));
    end
  end

  // ********
  // bus and helper tasks
  // ********
  function automatic logic [31:0] next_rand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic bus_addr(input logic [7:0] a, input logic wr);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= upd_ctrl_pkg::SIZE_WORD;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    bus_addr(a, 1'b1);
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
  endtask

  task automatic bus_read(input logic [7:0] a, input logic [31:0] e);
    readQ.push_back(e);
    bus_addr(a, 1'b0);
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
  endtask

  // bounded wait for a tick (1) or a commit (0)
  task automatic wait_for(input logic tick);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while ((tick ? rampTick : commitPulse) !== 1'b1 && n < 3000);
    if (n >= 3000)
    begin
      miscompares++;
      $display("BAD %0t wait expired", $time);
    end
  endtask

  // new amplitude must stay out of the working copy until a commit
  task automatic stage_amp(input logic [31:0] amp, input logic [31:0] old);
    bus_write(upd_ctrl_pkg::AMP_OFF, amp);
    bus_read(upd_ctrl_pkg::AMP_OFF, amp);
    bus_read(upd_ctrl_pkg::ACT_OFF, old);
    ampQ.push_back(amp);
  endtask

  // tick spacing around an action placed mid-interval
  task automatic gap_after(input int kind, output int gap);
    int t0;
    wait_for(1'b1);
    t0 = cyc;
    repeat (12) @(posedge clk_sys);
    if (kind == 1)
      strobe_host_model_inst.set_direction();
    else if (kind == 2)
      strobe_host_model_inst.commit_pulse();
    else if (kind == 3)
      strobe_host_model_inst.set_profile(3'h1);
    wait_for(1'b1);
    gap = cyc - t0;
  endtask

  // ********
  // main sequence
  // ********
  initial
  begin
    logic [31:0] amp;
    logic [31:0] old;
    int t0;
    int n;
    int gap;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    `CHK(stepSize, upd_ctrl_pkg::STEP_UNIT);
    `CHK(strobeOe, 1'b0);
    for (int i = 0; i < 6; i++)
      bus_read(8'(i * 4), 32'h0);
    bus_write(8'h14, 32'hFFFF_FFFF);
    bus_read(8'h14, 32'h0);
    bus_write(upd_ctrl_pkg::CTRL_OFF, 32'hFFFF_FFE0);
    bus_read(upd_ctrl_pkg::CTRL_OFF, 32'h0);
    old = 32'h0;
    for (int s = 0; s < 4; s++)
    begin
      amp = next_rand();
      amp[1:0] = 2'(s);
      stage_amp(amp, old);
      strobe_host_model_inst.commit_pulse();
      wait_for(1'b0);
      old = amp;
    end
    for (int p = 1; p < 9; p++)
    begin
      amp = next_rand();
      stage_amp(amp, old);
      strobe_host_model_inst.set_profile(3'(p));
      wait_for(1'b0);
      repeat (2) @(posedge clk_sys);
      `CHK(activeProfile, 3'(p));
      old = amp;
    end
    holdAmp <= old;
    autoMode <= 1'b1;
    bus_write(upd_ctrl_pkg::RATE_OFF, 32'h5);
    for (int a = 0; a < 4; a++)
    begin
      bus_write(upd_ctrl_pkg::CTRL_OFF, 32'(2 * a + 1));
      @(posedge clk_sys);
      `CHK(strobeOe, 1'b1);
      wait_for(1'b0);
      wait_for(1'b0);
      t0 = cyc;
      n = 1;
      while (n < 64)
      begin
        @(posedge clk_sys);
        if (strobeOut !== 1'b1)
          break;
        n++;
      end
      `CHK(n, upd_ctrl_pkg::PULSE_CYC);
      wait_for(1'b0);
      `CHK(cyc - t0, 4 * (1 << a) * 5);
    end
    // let the last twelve-cycle pulse end before the line is held high
    repeat (16) @(posedge clk_sys);
    bus_write(upd_ctrl_pkg::RATE_OFF, 32'h3);
    repeat (20) @(posedge clk_sys);
    autoMode <= 1'b0;
    n = 0;
    repeat (100)
    begin
      @(posedge clk_sys);
      if (strobeOut === 1'b1)
        n++;
    end
    `CHK(n, 100);
    bus_write(upd_ctrl_pkg::CTRL_OFF, 32'h0);
    @(posedge clk_sys);
    `CHK(strobeOe, 1'b0);
    amp = next_rand();
    amp[31:16] = 16'h0006;
    stage_amp(amp, old);
    bus_write(upd_ctrl_pkg::CTRL_OFF, 32'h8);
    strobe_host_model_inst.commit_pulse();
    wait_for(1'b0);
    gap_after(0, gap);
    `CHK(gap, 4 * 6);
    gap_after(1, gap);
    `CHK(gap > 30 && gap < 48, 1'b1);
    `CHK(rampUp, 1'b1);
    ampQ.push_back(amp);
    gap_after(2, gap);
    `CHK(gap, 4 * 6);
    bus_write(upd_ctrl_pkg::CTRL_OFF, 32'h18);
    ampQ.push_back(amp);
    gap_after(2, gap);
    `CHK(gap > 30 && gap < 48, 1'b1);
    ampQ.push_back(amp);
    gap_after(3, gap);
    `CHK(gap > 30 && gap < 48, 1'b1);
    repeat (10) @(posedge clk_sys);
    `CHK(ampQ.size(), 0);
    complete_run();
  end
endmodule
